/* File: src/tfc_top.sv */
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "tfc_regs.svh"

module tfc_top
(
	input wire logic REF_CLK,
	input wire logic RSTN,
	input wire logic [3:0] ADDRESS,
	input wire logic READ,
	input wire logic WRITE,
	input wire logic [31:0] WRITEDATA,
	input wire logic [3:0] BYTEENABLE,
	output logic [31:0] READDATA,
	output logic WAITREQUEST,
	input wire logic SCL_IN,
	output logic SCL_OUT,
	output logic SCL_OE,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE
);

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	localparam int WAIT_CYC = `TFC_WAIT_CYC; // Length of the clock-low wait.

	tfc_pkg::tfc_state_e state; // Shift engine state.
	tfc_pkg::tfc_code_t count; // Stored transfer bit count code.
	tfc_pkg::tfc_left_t left; // Bits still to move in the frame.
	logic order; // One selects least significant bit first.
	logic wait_en; // One asks for the wait before acknowledge.
	logic i2c_mode; // One selects I2C format, zero synchronous format.
	logic master; // One selects master mode.
	logic [7:0] tx_data; // Byte to send.
	logic [7:0] rx_data; // Byte received.
	logic [8:0] shreg; // Outgoing shift register.
	logic [5:0] wait_cnt; // Cycles left in the wait.
	logic [1:0] pin_lvl; // Clean pin levels, clock in bit zero.
	logic [1:0] pin_rise; // Rising edges of the pins.
	logic [1:0] pin_fall; // Falling edges of the pins.
	logic bus_go; // The access completes at this edge.
	logic wr_fmt; // Write to the format register completes.
	logic wr_ctrl; // Write to the control register completes.
	logic start; // Software asks for a frame.
	logic frame_end; // The last bit of the frame was sampled.
	logic bit_out; // Bit currently presented on the data line.
	logic wait_take; // The engine enters the wait now.
	logic seen_rise; // A clock rise was seen in this frame, so falls now shift.
	logic [2:0] code_rd; // Count field as software reads it.
	logic [31:0] next_rdata; // Read data for the pending access.

	// Access ends at the edge where the request meets a low wait request.
	assign bus_go = (READ || WRITE) && !WAITREQUEST;
	assign wr_fmt = bus_go && WRITE && BYTEENABLE[0] && (ADDRESS == `TFC_OFS_FORMAT);
	assign wr_ctrl = bus_go && WRITE && BYTEENABLE[0] && (ADDRESS == `TFC_OFS_CTRL);
	assign start = wr_ctrl && WRITEDATA[`TFC_BIT_START] && (state == tfc_pkg::TFC_IDLE);
	assign frame_end = (state == tfc_pkg::TFC_SHIFT) && pin_rise[0] && (left == 4'h1);
	assign bit_out = order ? shreg[0] : shreg[8];
	// The wait only exists in I2C master mode, before the acknowledge bit.
	assign wait_take = (state == tfc_pkg::TFC_SHIFT) && pin_fall[0] && (left == 4'h1)
		&& i2c_mode && master && wait_en;

	// ------------------------------------------------------------
	// Pin synchroniser
	// ------------------------------------------------------------
	tfc_pin_sync u_sync
	(
		.clk(REF_CLK),
		.rst_n(RSTN),
		.pin({SDA_IN, SCL_IN}),
		.level(pin_lvl),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	// Frame length in bits for a count code in the chosen format.
	function automatic tfc_pkg::tfc_left_t frame_len(input logic [2:0] code, input logic i2c);
		if (i2c)
		begin
			frame_len = (code == 3'h0) ? `TFC_I2C_FULL : {1'b0, code} + 4'h1;
		end
		else
		begin
			frame_len = (code == 3'h0) ? `TFC_CSI_FULL : {1'b0, code};
		end
	endfunction

	// Remaining bits turned back into a count code for reading.
	always_comb
	begin
		code_rd = count;
		if (state != tfc_pkg::TFC_IDLE)
		begin
			if (i2c_mode)
			begin
				code_rd = (left == `TFC_I2C_FULL) ? 3'h0 : 3'(left - 4'h1);
			end
			else
			begin
				code_rd = (left == `TFC_CSI_FULL) ? 3'h0 : left[2:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	// Read mux; unmapped addresses read as zero.
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		if (ADDRESS == `TFC_OFS_FORMAT)
		begin
			next_rdata[7:0] = {order, wait_en, `TFC_RSV_ONES, code_rd};
		end
		else if (ADDRESS == `TFC_OFS_CTRL)
		begin
			next_rdata[2:0] = {state != tfc_pkg::TFC_IDLE, master, i2c_mode};
		end
		else if (ADDRESS == `TFC_OFS_DATA)
		begin
			next_rdata[7:0] = rx_data;
		end
	end

	// Wait request drops for one cycle after a request is seen.
	always_ff @(posedge REF_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			WAITREQUEST <= 1'b1;
			READDATA <= 32'h0000_0000;
		end
		else
		begin
			WAITREQUEST <= !((READ || WRITE) && WAITREQUEST);
			if (READ && WAITREQUEST)
			begin
				READDATA <= next_rdata;
			end
		end
	end

	// Format fields other than the count.
	always_ff @(posedge REF_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			order <= 1'b0;
			wait_en <= 1'b0;
		end
		else if (wr_fmt)
		begin
			order <= WRITEDATA[`TFC_BIT_ORDER];
			wait_en <= WRITEDATA[`TFC_BIT_WAIT];
		end
	end

	// Count code: loaded only when unprotected; otherwise cleared when a frame ends.
	always_ff @(posedge REF_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			count <= `TFC_RST_COUNT;
		end
		else if (wr_fmt && !WRITEDATA[`TFC_BIT_PROTECT])
		begin
			count <= WRITEDATA[2:0];
		end
		else if (frame_end)
		begin
			count <= 3'h0;
		end
	end

	// Mode and transmit data.
	always_ff @(posedge REF_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			i2c_mode <= 1'b0;
			master <= 1'b0;
			tx_data <= `TFC_RST_TXDATA;
		end
		else
		begin
			if (wr_ctrl)
			begin
				i2c_mode <= WRITEDATA[`TFC_BIT_I2C];
				master <= WRITEDATA[`TFC_BIT_MASTER];
			end
			if (bus_go && WRITE && BYTEENABLE[0] && (ADDRESS == `TFC_OFS_DATA))
			begin
				tx_data <= WRITEDATA[7:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Shift engine
	// ------------------------------------------------------------
	// Data moves out on clock falls and in on clock rises.
	always_ff @(posedge REF_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			state <= tfc_pkg::TFC_IDLE;
			left <= 4'h0;
			shreg <= 9'h1ff;
			rx_data <= 8'h00;
			seen_rise <= 1'b0;
			wait_cnt <= 6'h00;
			SCL_OE <= 1'b0;
		end
		else
		begin
			case (state)
				tfc_pkg::TFC_IDLE:
				begin
					if (start)
					begin
						left <= frame_len(count, i2c_mode);
						// The spare bit releases the line after the data.
						shreg <= order ? {1'b1, tx_data} : {tx_data, 1'b1};
						// The first bit already stands; the opening fall must not shift it.
						seen_rise <= 1'b0;
						state <= tfc_pkg::TFC_SHIFT;
					end
				end
				tfc_pkg::TFC_SHIFT:
				begin
					if (pin_rise[0])
					begin
						// The acknowledge bit of an I2C frame is not stored.
						if (!(i2c_mode && left == 4'h1))
						begin
							rx_data <= order ? {pin_lvl[1], rx_data[7:1]} : {rx_data[6:0], pin_lvl[1]};
						end
						left <= left - 4'h1;
						seen_rise <= 1'b1;
						if (left == 4'h1)
						begin
							state <= tfc_pkg::TFC_IDLE;
						end
					end
					else if (pin_fall[0] && seen_rise)
					begin
						// The acknowledge bit of an I2C frame leaves the data line released.
						if (i2c_mode && left == 4'h1)
						begin
							shreg <= 9'h1ff;
						end
						else
						begin
							shreg <= order ? {1'b1, shreg[8:1]} : {shreg[7:0], 1'b1};
						end
						if (wait_take)
						begin
							wait_cnt <= 6'(WAIT_CYC - 1);
							SCL_OE <= 1'b1;
							state <= tfc_pkg::TFC_WAIT;
						end
					end
				end
				tfc_pkg::TFC_WAIT:
				begin
					// Clock is held low; its edges are ignored here.
					if (wait_cnt == 6'h00)
					begin
						SCL_OE <= 1'b0;
						state <= tfc_pkg::TFC_SHIFT;
					end
					else
					begin
						wait_cnt <= wait_cnt - 6'h01;
					end
				end
				default:
				begin
					state <= tfc_pkg::TFC_IDLE;
				end
			endcase
		end
	end

	// Line drivers: data line open drain in I2C format, push-pull otherwise; clock line only ever pulled low.
	always_ff @(posedge REF_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			SCL_OUT <= 1'b0;
			SDA_OUT <= 1'b0;
			SDA_OE <= 1'b0;
		end
		else
		begin
			SCL_OUT <= 1'b0;
			SDA_OUT <= i2c_mode ? 1'b0 : bit_out;
			SDA_OE <= (state != tfc_pkg::TFC_IDLE) && (i2c_mode ? !bit_out : 1'b1);
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_msb_first_load: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		(start && !order) |=> bit_out == $past(tx_data[7]))
		else $error("First bit is not the top data bit.");

	a_lsb_first_load: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		(start && order) |=> bit_out == $past(tx_data[0]))
		else $error("First bit is not the bottom data bit.");

	// Counts the cycles for which the clock has been held low by the wait.
	logic [5:0] oe_run;
	always_ff @(posedge REF_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			oe_run <= 6'h00;
		end
		else
		begin
			oe_run <= SCL_OE ? oe_run + 6'h01 : 6'h00;
		end
	end

	a_wait_clock_low: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		wait_take |=> SCL_OE [*8])
		else $error("Wait does not hold the clock low at once.");

	a_wait_length: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		$fell(SCL_OE) |-> oe_run == 6'(WAIT_CYC))
		else $error("Wait does not hold the clock low for two transfer clocks.");

	a_no_wait_gap: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		(state == tfc_pkg::TFC_SHIFT && pin_fall[0] && !wait_en) |=> !SCL_OE)
		else $error("Clock held low with wait cleared.");

	a_wait_mode_only: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		(state == tfc_pkg::TFC_SHIFT && (!i2c_mode || !master)) |=> state != tfc_pkg::TFC_WAIT)
		else $error("Wait inserted outside I2C master mode.");

	a_reserved_ones: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		(READ && WAITREQUEST && ADDRESS == `TFC_OFS_FORMAT) |=> READDATA[5:4] == 2'b11)
		else $error("Reserved format bits do not read one.");

	a_count_load: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		(wr_fmt && !WRITEDATA[`TFC_BIT_PROTECT]) |=> count == $past(WRITEDATA[2:0]))
		else $error("Unprotected write did not load the count.");

	a_count_protect: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		(wr_fmt && WRITEDATA[`TFC_BIT_PROTECT] && !frame_end) |=> $stable(count))
		else $error("Protected write changed the count.");

	a_protect_reads: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		(READ && WAITREQUEST && ADDRESS == `TFC_OFS_FORMAT) |=> READDATA[3])
		else $error("Protect bit does not read one.");

	a_i2c_length: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		(start && i2c_mode) |=> left == (($past(count) == 3'h0) ? 4'h9 : {1'b0, $past(count)} + 4'h1))
		else $error("I2C frame length wrong.");

	a_csi_length: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		(start && !i2c_mode) |=> left == (($past(count) == 3'h0) ? 4'h8 : {1'b0, $past(count)}))
		else $error("Synchronous frame length wrong.");

	a_remaining_read: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		(READ && WAITREQUEST && ADDRESS == `TFC_OFS_FORMAT && state == tfc_pkg::TFC_SHIFT
		&& i2c_mode && left != 4'h9) |=> READDATA[2:0] == $past(left[2:0]) - 3'h1)
		else $error("Count read does not show remaining bits.");

	a_frame_done: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		(frame_end && !wr_fmt) |=> state == tfc_pkg::TFC_IDLE && count == 3'h0 && left == 4'h0)
		else $error("Frame end did not return the count to zero.");

endmodule

`default_nettype wire

/* File: src/tfc_regs.svh */
`ifndef TFC_REGS_SVH
`define TFC_REGS_SVH

// Byte offsets of the registers on the bus.
`define TFC_OFS_FORMAT 4'h0
`define TFC_OFS_CTRL 4'h4
`define TFC_OFS_DATA 4'h8

// Field positions in the transfer format control register.
`define TFC_BIT_ORDER 7
`define TFC_BIT_WAIT 6
`define TFC_BIT_PROTECT 3
`define TFC_RSV_ONES 3'h7

// Field positions in the control register.
`define TFC_BIT_I2C 0
`define TFC_BIT_MASTER 1
`define TFC_BIT_START 2

// Reset values.
`define TFC_RST_COUNT 3'h0
`define TFC_RST_TXDATA 8'h00

// Frame lengths for counter code zero in each format.
`define TFC_I2C_FULL 4'h9
`define TFC_CSI_FULL 4'h8

// Timing: system clock period and one transfer clock, both in ns.
`define TFC_CLK_NS 8
`define TFC_XFER_CLK_NS 125
// Wait extension is two transfer clocks, a least time so it rounds up.
`define TFC_WAIT_CYC ((2 * `TFC_XFER_CLK_NS + `TFC_CLK_NS - 1) / `TFC_CLK_NS)

`endif

/* File: src/tfc_pkg.sv */
`default_nettype none

package tfc_pkg;

	// States of the serial shift engine.
	typedef enum logic [1:0]
	{
		TFC_IDLE = 2'b00,
		TFC_SHIFT = 2'b01,
		TFC_WAIT = 2'b10
	} tfc_state_e;

	// Three-bit transfer bit count code.
	typedef logic [2:0] tfc_code_t;

	// Count of bits still to move in a frame.
	typedef logic [3:0] tfc_left_t;

endpackage

`default_nettype wire

/* File: src/tfc_pin_sync.sv */
`timescale 1ns/10ps
`default_nettype none

// Brings pins into the clock domain through three flip-flops per bit and
// reports clean levels and one-cycle edge pulses.
module tfc_pin_sync
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [1:0] pin,
	output logic [1:0] level,
	output logic [1:0] rise,
	output logic [1:0] fall
);

	genvar i;

	generate
		for (i = 0; i < 2; i = i + 1)
		begin : g_bit
			logic s1; // First stage, read only by the second.
			logic s2; // Second stage.
			logic s3; // Third stage.

			// A change is accepted only once the second and third stages agree.
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					s1 <= 1'b1;
					s2 <= 1'b1;
					s3 <= 1'b1;
					level[i] <= 1'b1;
					rise[i] <= 1'b0;
					fall[i] <= 1'b0;
				end
				else
				begin
					s1 <= pin[i];
					s2 <= s1;
					s3 <= s2;
					rise[i] <= (s2 == s3) && s3 && !level[i];
					fall[i] <= (s2 == s3) && !s3 && level[i];
					if (s2 == s3)
					begin
						level[i] <= s3;
					end
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

/* File: dv/tfc_peer.sv */
`timescale 1ns/10ps
`default_nettype none

// -----------------------------------------------------------------
// Serial peer: makes the link clock only inside frames.
// -----------------------------------------------------------------
module tfc_peer
(
	input wire logic scl_line,
	input wire logic sda_line,
	output logic scl_drv,
	output logic sda_drv
);
	// Bits seen on the data line at each clock rise, in wire order.
	logic [8:0] bits;

	// The clock rests high and the data line is released to its pull-up.
	initial
	begin
		scl_drv = 1'b1;
		sda_drv = 1'b1;
		bits = 9'h000;
	end

	// Sends n clock pulses of 125 ns for bits first onwards, then stands still.
	task automatic run(input int first, input int n);
		int i;
		int k;
		for (i = first; i < first + n; i++)
		begin
			scl_drv = 1'b0;
			#62.5;
			scl_drv = 1'b1;
			k = 0;
			// A stretched low is waited out before the high half starts.
			while (scl_line !== 1'b1 && k < 2000)
			begin
				#8;
				k++;
			end
			bits[i] = sda_line;
			#62.5;
		end
	endtask
endmodule

`default_nettype wire

/* File: dv/tfc_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "tfc_regs.svh"

// -----------------------------------------------------------------
// Self-checking bench for the transfer format block.
// -----------------------------------------------------------------
module tfc_top_tb;
	logic REF_CLK;
	logic RSTN;
	logic [3:0] ADDRESS;
	logic READ;
	logic WRITE;
	logic [31:0] WRITEDATA;
	logic [3:0] BYTEENABLE;
	logic [31:0] READDATA;
	logic WAITREQUEST;
	logic SCL_OUT;
	logic SCL_OE;
	logic SDA_OUT;
	logic SDA_OE;
	wire scl_line;
	wire sda_line;
	logic scl_drv;
	logic sda_drv;
	int n_mismatch;
	int compares;
	int cyc;
	int oe_cyc;
	int seed;
	logic [7:0] rx_exp; // Receive byte as the stored wire bits should build it.
	// Corner frames: i2c, master, wait, order, code.
	logic [6:0] tbl [6] = '{7'b1110000, 7'b1100111, 7'b1010001,
		7'b0111000, 7'b0000001, 7'b0001111};

	// Open-drain wires resolve against the peer; released lines pull high.
	assign scl_line = SCL_OE ? SCL_OUT : scl_drv;
	assign sda_line = SDA_OE ? SDA_OUT : sda_drv;

	tfc_top i_tfc_top (.REF_CLK(REF_CLK), .RSTN(RSTN), .ADDRESS(ADDRESS), .READ(READ),
		.WRITE(WRITE), .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE),
		.READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .SCL_IN(scl_line),
		.SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .SDA_IN(sda_line), .SDA_OUT(SDA_OUT),
		.SDA_OE(SDA_OE));

	tfc_peer i_tfc_peer (.scl_line(scl_line), .sda_line(sda_line), .scl_drv(scl_drv),
		.sda_drv(sda_drv));

	// -----------------------------------------------------------------
	// Clock, timeout and the stretch counter.
	// -----------------------------------------------------------------
	always #4 REF_CLK = ~REF_CLK;

	// Counts cycles of held serial clock and cuts a hang short.
	always @(posedge REF_CLK)
	begin
		cyc++;
		if (SCL_OE === 1'b1)
			oe_cyc++;
		if (cyc == 60000)
		begin
			n_mismatch++;
			give_verdict();
		end
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic give_verdict();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Compares a value and reports a difference at once.
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// One bus access held until waitrequest is seen low.
	task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge REF_CLK);
		ADDRESS <= a;
		WRITE <= wr;
		READ <= !wr;
		WRITEDATA <= {24'h000000, d};
		do
			@(posedge REF_CLK);
		while (WAITREQUEST !== 1'b0);
		q = READDATA;
		WRITE <= 1'b0;
		READ <= 1'b0;
	endtask

	// Bits in a frame for a format and a count code.
	function automatic int frame_len(input logic i2c, input logic [2:0] c);
		if (i2c)
			return (c == 3'h0) ? 9 : int'(c) + 1;
		return (c == 3'h0) ? 8 : int'(c);
	endfunction

	// Runs one frame and checks wire bits, stretch, status and count.
	task automatic frame(input logic i2c, input logic m, input logic w, input logic o,
		input logic [2:0] c, input logic [7:0] tx);
		logic [31:0] q;
		logic b;
		int n;
		int i;
		n = frame_len(i2c, c);
		bus(1'b1, `TFC_OFS_CTRL, 8'h01, q);
		bus(1'b1, `TFC_OFS_FORMAT, {o, w, 3'h0, c}, q);
		bus(1'b1, `TFC_OFS_DATA, tx, q);
		bus(1'b1, `TFC_OFS_CTRL, {6'h00, m, i2c}, q);
		oe_cyc = 0;
		bus(1'b1, `TFC_OFS_CTRL, {5'h00, 1'b1, m, i2c}, q);
		i_tfc_peer.run(0, 1);
		bus(1'b0, `TFC_OFS_FORMAT, 8'h00, q);
		chk(q, {24'h0, o, w, 3'h7, 3'(i2c ? n - 2 : n - 1)});
		i_tfc_peer.run(1, n - 1);
		q = 32'h4;
		for (i = 0; i < 50 && q[2] !== 1'b0; i++)
			bus(1'b0, `TFC_OFS_CTRL, 8'h00, q);
		chk(q, {30'h0, m, i2c});
		chk(oe_cyc, (i2c && m && w) ? `TFC_WAIT_CYC : 0);
		bus(1'b0, `TFC_OFS_FORMAT, 8'h00, q);
		chk(q, {24'h0, o, w, 6'h38});
		for (i = 0; i < (i2c ? n - 1 : n); i++)
		begin
			b = o ? tx[i] : tx[7 - i];
			chk(i_tfc_peer.bits[i], b);
			rx_exp = o ? {b, rx_exp[7:1]} : {rx_exp[6:0], b};
		end
		if (i2c)
			chk(i_tfc_peer.bits[n - 1], 1'b1);
		bus(1'b0, `TFC_OFS_DATA, 8'h00, q);
		chk(q, {24'h0, rx_exp});
	endtask

	// -----------------------------------------------------------------
	// Main sequence.
	// -----------------------------------------------------------------
	initial
	begin
		logic [31:0] q;
		logic [6:0] s;
		int k;
		REF_CLK = 1'b0;
		RSTN = 1'b0;
		{ADDRESS, READ, WRITE, WRITEDATA} = '0;
		BYTEENABLE = 4'hf;
		n_mismatch = 0;
		compares = 0;
		cyc = 0;
		seed = 32'hed7f;
		rx_exp = 8'h00;
		repeat (4) @(posedge REF_CLK);
		RSTN <= 1'b1;
		bus(1'b0, `TFC_OFS_FORMAT, 8'h00, q);
		chk(q, 32'h38);
		bus(1'b1, `TFC_OFS_CTRL, 8'h01, q);
		bus(1'b1, `TFC_OFS_FORMAT, 8'h0d, q);
		bus(1'b0, `TFC_OFS_FORMAT, 8'h00, q);
		chk(q, 32'h38);
		bus(1'b1, `TFC_OFS_FORMAT, 8'h05, q);
		bus(1'b0, `TFC_OFS_FORMAT, 8'h00, q);
		chk(q, 32'h3d);
		// A write without its low byte enabled is dropped.
		BYTEENABLE <= 4'he;
		bus(1'b1, `TFC_OFS_FORMAT, 8'h42, q);
		BYTEENABLE <= 4'hf;
		bus(1'b1, 4'hc, 8'hff, q);
		bus(1'b0, 4'hc, 8'h00, q);
		chk(q, 32'h0);
		bus(1'b0, `TFC_OFS_FORMAT, 8'h00, q);
		chk(q, 32'h3d);
		// Corner frames first, then random ones.
		for (k = 0; k < 30; k++)
		begin
			s = (k < 6) ? tbl[k] : 7'($random(seed));
			if (s[6])
				s[3] = 1'b0;
			frame(s[6], s[5], s[4], s[3], s[2:0], 8'($random(seed)));
		end
		give_verdict();
	end
endmodule

`default_nettype wire
